// file: common/pidc_pkg.sv
// constants, register map and carrier types of the loop controller
package pidc_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] GAIN_OFS  = 8'h04;
    localparam logic [7:0] FINE_OFS  = 8'h08;
    localparam logic [7:0] ITIME_OFS = 8'h0c;
    localparam logic [7:0] RTIME_OFS = 8'h10;
    localparam logic [7:0] FTIME_OFS = 8'h14;
    localparam logic [7:0] UPPER_OFS = 8'h18;
    localparam logic [7:0] LOWER_OFS = 8'h1c;
    localparam logic [7:0] RATIO_OFS = 8'h20;
    localparam logic [7:0] PROF_OFS  = 8'h24;
    localparam logic [7:0] STAT_OFS  = 8'h28;
    localparam logic [7:0] ERR_OFS   = 8'h2c;
    localparam logic [7:0] RES_OFS   = 8'h30;
    localparam logic [7:0] SP_OFS    = 8'h34;
    localparam logic [7:0] FB_OFS    = 8'h38;
    // control and ratio register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_INH_BIT  = 1;
    localparam int CTRL_LEG_BIT  = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int RATIO2_LSB    = 16;
    // number formats: percent values Q4.12 (100 % = 'h1000), gains Q8.8, coefficients Q0.16
    localparam int FRAC      = 12;
    localparam int GAIN_FRAC = 8;
    localparam int COEF_FRAC = 16;
    localparam int LEG_SHIFT = 2;
    localparam logic signed [31:0] ERR_MAX = 32'sd4300;
    // reset values
    localparam logic [15:0] GAIN_RST  = 16'h0100;
    localparam logic [15:0] RATIO_RST = 16'h1000;
    localparam logic [15:0] ZERO16    = 16'h0000;
    // control sample tick
    localparam int SAMPLE_US     = 1000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAMPLE_CYCLES = SAMPLE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PIDC_P,
        PIDC_PD,
        PIDC_PI,
        PIDC_PID
    } pidc_terms_t;

    typedef struct packed {
        logic               enable;
        logic               integral_inhibit;
        logic               legacy_timing_select;
        pidc_terms_t        terms;
        logic [15:0]        gain;
        logic [15:0]        fine_gain_addend;
        logic [15:0]        int_coef;
        logic [15:0]        rate_time_setting;
        logic [15:0]        filt_coef;
        logic signed [15:0] upper_output_bound;
        logic signed [15:0] lower_output_bound;
        logic signed [15:0] ratio1;
        logic signed [15:0] ratio2;
        logic [7:0]         profile_sel;
    } pidc_cfg_t;
endpackage : pidc_pkg

// file: hdl/pidc_top.sv
// three-term loop controller with apb register file
`timescale 1ns/100ps
// Overview of operation
// RQ1: error is scaled setpoint minus scaled feedback
// RQ2: error saturated at plus/minus 105 percent
// RQ3: proportional term is error times gain
// RQ4: terms weighted by gain, integral, rate settings
// RQ5: derivative term passes a low-pass filter
// RQ6: selectable P, PD, PI or PID
// RQ7: external profiled gain may replace gain
// RQ8: profile select zero keeps constant gain
// RQ9: integral bounded by output bounds
// RQ10: integral frozen while limit hit
// RQ11: inhibit removes integral contribution
// RQ12: legacy timing makes time constants fourfold
// RQ13: host normally leaves rate time zero
// RQ14: error, result, setpoint, feedback readable
// RQ15: bounds held within 0..105 and -105..0
// RQ16: disabled block drives zero result
// RQ17: fine addend summed into proportional gain
// RQ18: each input scaled by own ratio
// RQ19: result clamped, limit flag on clamp
// RQ20: states update once per sample tick
module pidc_top #(
    parameter int SAMPLE_CYCLES = pidc_pkg::SAMPLE_CYCLES
) (
    input  wire logic                     i_mclk,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_psel,
    input  wire logic                     i_penable,
    input  wire logic                     i_pwrite,
    input  wire logic [pidc_pkg::AW-1:0]  i_paddr,
    input  wire logic [pidc_pkg::DW-1:0]  i_pwdata,
    output logic      [pidc_pkg::DW-1:0]  o_prdata,
    output logic                          o_pready,
    output logic                          o_pslverr,
    input  wire logic signed [15:0]       i_setpoint,
    input  wire logic signed [15:0]       i_feedback,
    input  wire logic [15:0]              i_profiled_gain,
    output logic signed [15:0]            o_loop_result,
    output logic signed [15:0]            o_loop_error_value,
    output logic                          o_limit_hit_flag
);
    if (SAMPLE_CYCLES < 16) begin : g_chk
        $error("SAMPLE_CYCLES too small");
    end

    function automatic logic signed [31:0] pidc_clamp(input logic signed [31:0] x,
                                                      input logic signed [31:0] lo,
                                                      input logic signed [31:0] hi);
        if (x > hi) return hi;
        if (x < lo) return lo;
        return x;
    endfunction : pidc_clamp

    pidc_pkg::pidc_cfg_t cfg_reg, cfg_next;
    logic [31:0]         cnt_reg, cnt_next;
    logic                tick_reg, tick_next;
    logic signed [31:0]  integ_reg, integ_next;
    logic signed [31:0]  filt_reg, filt_next;
    logic signed [31:0]  prev_err_reg, prev_err_next;
    logic signed [31:0]  dterm_reg, dterm_next;
    logic signed [15:0]  result_reg, result_next;
    logic signed [15:0]  err_reg, err_next;
    logic signed [15:0]  sp_reg, sp_next;
    logic signed [15:0]  fb_reg, fb_next;
    logic                hit_reg, hit_next;
    logic [31:0]         prdata_reg, prdata_next;
    logic                pready_reg, pready_next;
    logic                pslverr_reg, pslverr_next;

    // sample tick
    always_comb begin
        cnt_next  = (cnt_reg == 32'(SAMPLE_CYCLES - 1)) ? 32'h0 : cnt_reg + 32'h1;
        tick_next = (cnt_reg == 32'(SAMPLE_CYCLES - 1));
    end

    // loop arithmetic
    logic signed [47:0] sp_prod, fb_prod, p_prod, i_prod, d_prod, f_prod;
    logic signed [31:0] sp_s, fb_s, err_raw, err_c, p_term, i_inc, i_cand, d_raw, d_filt, sum;
    logic [17:0]        gain_tot;
    logic               use_i, use_d, leg;
    logic signed [31:0] lo_b, hi_b;

    always_comb begin
        leg     = cfg_reg.legacy_timing_select;
        use_i   = (cfg_reg.terms == pidc_pkg::PIDC_PI || cfg_reg.terms == pidc_pkg::PIDC_PID)
                  && !cfg_reg.integral_inhibit; // RQ6 RQ11
        use_d   = (cfg_reg.terms == pidc_pkg::PIDC_PD || cfg_reg.terms == pidc_pkg::PIDC_PID); // RQ6
        lo_b    = 32'(cfg_reg.lower_output_bound);
        hi_b    = 32'(cfg_reg.upper_output_bound);
        sp_prod = 48'(i_setpoint) * 48'(cfg_reg.ratio1); // RQ18
        fb_prod = 48'(i_feedback) * 48'(cfg_reg.ratio2); // RQ18
        sp_s    = 32'(sp_prod >>> pidc_pkg::FRAC);
        fb_s    = 32'(fb_prod >>> pidc_pkg::FRAC);
        err_raw = sp_s - fb_s; // RQ1
        err_c   = pidc_clamp(err_raw, -pidc_pkg::ERR_MAX, pidc_pkg::ERR_MAX); // RQ2
        // profiled gain replaces the main gain; the fine addend always adds on
        gain_tot = (cfg_reg.profile_sel == 8'h00) ? {2'b00, cfg_reg.gain} : {2'b00, i_profiled_gain}; // RQ7 RQ8
        gain_tot = gain_tot + {2'b00, cfg_reg.fine_gain_addend}; // RQ17
        p_prod  = 48'(err_c) * $signed({30'h0, gain_tot}); // RQ3 RQ4
        p_term  = 32'(p_prod >>> pidc_pkg::GAIN_FRAC);
        // longer time constant means smaller integral step and larger rate gain
        i_prod  = 48'(err_c) * $signed({32'h0, cfg_reg.int_coef}); // RQ4
        i_inc   = leg ? 32'(i_prod >>> (pidc_pkg::COEF_FRAC + pidc_pkg::LEG_SHIFT))
                      : 32'(i_prod >>> pidc_pkg::COEF_FRAC); // RQ12
        i_cand  = pidc_clamp(integ_reg + i_inc, lo_b, hi_b); // RQ9
        d_prod  = 48'(err_c - prev_err_reg) * $signed({32'h0, cfg_reg.rate_time_setting}); // RQ4
        d_raw   = leg ? 32'(d_prod >>> (pidc_pkg::GAIN_FRAC - pidc_pkg::LEG_SHIFT))
                      : 32'(d_prod >>> pidc_pkg::GAIN_FRAC); // RQ12
        f_prod  = 48'(d_raw - filt_reg) * $signed({32'h0, cfg_reg.filt_coef}); // RQ5
        d_filt  = (cfg_reg.filt_coef == 16'h0) ? d_raw
                : leg ? filt_reg + 32'(f_prod >>> (pidc_pkg::COEF_FRAC + pidc_pkg::LEG_SHIFT))
                      : filt_reg + 32'(f_prod >>> pidc_pkg::COEF_FRAC); // RQ5 RQ12
        integ_next    = integ_reg;
        filt_next     = filt_reg;
        prev_err_next = prev_err_reg;
        dterm_next    = dterm_reg;
        result_next   = result_reg;
        err_next      = err_reg;
        sp_next       = sp_reg;
        fb_next       = fb_reg;
        hit_next      = hit_reg;
        sum           = p_term + (use_i ? integ_reg : 32'h0) + (use_d ? dterm_reg : 32'h0);
        if (tick_reg) begin // RQ20
            if (!use_i) begin
                integ_next = 32'h0; // RQ11
            end else if (!hit_reg) begin // RQ10
                integ_next = i_cand; // RQ9
            end
            filt_next     = use_d ? d_filt : 32'h0; // RQ5
            dterm_next    = use_d ? d_filt : 32'h0; // RQ6
            prev_err_next = err_c;
            err_next      = 16'(err_c); // RQ14
            sp_next       = 16'(sp_s);
            fb_next       = 16'(fb_s);
            hit_next      = (sum > hi_b) || (sum < lo_b); // RQ19
            result_next   = cfg_reg.enable ? 16'(pidc_clamp(sum, lo_b, hi_b)) : 16'sh0; // RQ16 RQ19
        end
    end

    // apb slave: zero wait states, read data captured in the setup cycle
    logic setup, wr_acc, mapped;
    logic signed [31:0] wval;
    always_comb begin
        setup  = i_psel && !i_penable;
        wr_acc = i_psel && i_penable && pready_reg && i_pwrite;
        unique case (i_paddr)
            pidc_pkg::CTRL_OFS, pidc_pkg::GAIN_OFS, pidc_pkg::FINE_OFS, pidc_pkg::ITIME_OFS,
            pidc_pkg::RTIME_OFS, pidc_pkg::FTIME_OFS, pidc_pkg::UPPER_OFS, pidc_pkg::LOWER_OFS,
            pidc_pkg::RATIO_OFS, pidc_pkg::PROF_OFS, pidc_pkg::STAT_OFS, pidc_pkg::ERR_OFS,
            pidc_pkg::RES_OFS, pidc_pkg::SP_OFS, pidc_pkg::FB_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        wval         = 32'($signed(i_pwdata[15:0]));
        pready_next  = setup;
        pslverr_next = setup && !mapped;
        prdata_next  = prdata_reg;
        if (setup && !i_pwrite) begin
            unique case (i_paddr)
                pidc_pkg::CTRL_OFS:  prdata_next = {26'h0, cfg_reg.terms, 1'b0, cfg_reg.legacy_timing_select,
                                                    cfg_reg.integral_inhibit, cfg_reg.enable};
                pidc_pkg::GAIN_OFS:  prdata_next = {16'h0, cfg_reg.gain};
                pidc_pkg::FINE_OFS:  prdata_next = {16'h0, cfg_reg.fine_gain_addend};
                pidc_pkg::ITIME_OFS: prdata_next = {16'h0, cfg_reg.int_coef};
                pidc_pkg::RTIME_OFS: prdata_next = {16'h0, cfg_reg.rate_time_setting};
                pidc_pkg::FTIME_OFS: prdata_next = {16'h0, cfg_reg.filt_coef};
                pidc_pkg::UPPER_OFS: prdata_next = 32'(cfg_reg.upper_output_bound);
                pidc_pkg::LOWER_OFS: prdata_next = 32'(cfg_reg.lower_output_bound);
                pidc_pkg::RATIO_OFS: prdata_next = {cfg_reg.ratio2, cfg_reg.ratio1};
                pidc_pkg::PROF_OFS:  prdata_next = {24'h0, cfg_reg.profile_sel};
                pidc_pkg::STAT_OFS:  prdata_next = {31'h0, hit_reg};
                pidc_pkg::ERR_OFS:   prdata_next = 32'(err_reg); // RQ14
                pidc_pkg::RES_OFS:   prdata_next = 32'(result_reg); // RQ14
                pidc_pkg::SP_OFS:    prdata_next = 32'(sp_reg); // RQ14
                pidc_pkg::FB_OFS:    prdata_next = 32'(fb_reg); // RQ14
                default:             prdata_next = 32'h0;
            endcase
        end
        cfg_next = cfg_reg;
        if (wr_acc) begin
            unique case (i_paddr)
                pidc_pkg::CTRL_OFS: begin
                    cfg_next.enable               = i_pwdata[pidc_pkg::CTRL_EN_BIT];
                    cfg_next.integral_inhibit     = i_pwdata[pidc_pkg::CTRL_INH_BIT];
                    cfg_next.legacy_timing_select = i_pwdata[pidc_pkg::CTRL_LEG_BIT];
                    cfg_next.terms = pidc_pkg::pidc_terms_t'(i_pwdata[pidc_pkg::CTRL_MODE_LSB +: 2]);
                end
                pidc_pkg::GAIN_OFS:  cfg_next.gain              = i_pwdata[15:0];
                pidc_pkg::FINE_OFS:  cfg_next.fine_gain_addend  = i_pwdata[15:0];
                pidc_pkg::ITIME_OFS: cfg_next.int_coef          = i_pwdata[15:0];
                pidc_pkg::RTIME_OFS: cfg_next.rate_time_setting = i_pwdata[15:0];
                pidc_pkg::FTIME_OFS: cfg_next.filt_coef         = i_pwdata[15:0];
                // out-of-range bounds are pinned rather than refused
                pidc_pkg::UPPER_OFS: cfg_next.upper_output_bound =
                    16'(pidc_clamp(wval, 32'sh0, pidc_pkg::ERR_MAX)); // RQ15
                pidc_pkg::LOWER_OFS: cfg_next.lower_output_bound =
                    16'(pidc_clamp(wval, -pidc_pkg::ERR_MAX, 32'sh0)); // RQ15
                pidc_pkg::RATIO_OFS: begin
                    cfg_next.ratio1 = i_pwdata[15:0];
                    cfg_next.ratio2 = i_pwdata[pidc_pkg::RATIO2_LSB +: 16];
                end
                pidc_pkg::PROF_OFS:  cfg_next.profile_sel = i_pwdata[7:0];
                default:             cfg_next = cfg_reg; // read-only words ignore writes
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_reg                    <= '0;
            cfg_reg.terms              <= pidc_pkg::PIDC_PI;
            cfg_reg.gain               <= pidc_pkg::GAIN_RST;
            cfg_reg.rate_time_setting  <= pidc_pkg::ZERO16; // RQ13
            cfg_reg.upper_output_bound <= 16'(pidc_pkg::ERR_MAX);
            cfg_reg.lower_output_bound <= 16'(-pidc_pkg::ERR_MAX);
            cfg_reg.ratio1             <= pidc_pkg::RATIO_RST;
            cfg_reg.ratio2             <= pidc_pkg::RATIO_RST;
            cnt_reg      <= 32'h0;
            tick_reg     <= 1'b0;
            integ_reg    <= 32'h0;
            filt_reg     <= 32'h0;
            prev_err_reg <= 32'h0;
            dterm_reg    <= 32'h0;
            result_reg   <= 16'sh0;
            err_reg      <= 16'sh0;
            sp_reg       <= 16'sh0;
            fb_reg       <= 16'sh0;
            hit_reg      <= 1'b0;
            prdata_reg   <= 32'h0;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            cnt_reg      <= cnt_next;
            tick_reg     <= tick_next;
            integ_reg    <= integ_next;
            filt_reg     <= filt_next;
            prev_err_reg <= prev_err_next;
            dterm_reg    <= dterm_next;
            result_reg   <= result_next;
            err_reg      <= err_next;
            sp_reg       <= sp_next;
            fb_reg       <= fb_next;
            hit_reg      <= hit_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    assign o_prdata           = prdata_reg;
    assign o_pready           = pready_reg;
    assign o_pslverr          = pslverr_reg;
    assign o_loop_result      = result_reg;
    assign o_loop_error_value = err_reg;
    assign o_limit_hit_flag   = hit_reg;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    err_saturate_a: assert property ( // RQ2
        tick_reg |=> (o_loop_error_value <= 16'sd4300) && (o_loop_error_value >= -16'sd4300))
        else $error("loop error beyond saturation");
    result_upper_a: assert property ( // RQ19
        tick_reg |=> o_loop_result <= $past(cfg_reg.upper_output_bound))
        else $error("result above upper bound");
    result_lower_a: assert property ( // RQ19
        tick_reg |=> o_loop_result >= $past(cfg_reg.lower_output_bound))
        else $error("result below lower bound");
    disabled_zero_a: assert property ( // RQ16
        tick_reg && !cfg_reg.enable |=> o_loop_result == 16'sh0)
        else $error("result driven while disabled");
    integ_freeze_a: assert property ( // RQ10
        tick_reg && hit_reg && use_i |=> $stable(integ_reg))
        else $error("integral moved while clamped");
    integ_inhibit_a: assert property ( // RQ11
        tick_reg && cfg_reg.integral_inhibit |=> integ_reg == 32'h0)
        else $error("integral kept while inhibited");
    integ_bound_a: assert property ( // RQ9
        tick_reg && use_i && !hit_reg |=> integ_reg <= 32'($past(cfg_reg.upper_output_bound))
                                        && integ_reg >= 32'($past(cfg_reg.lower_output_bound)))
        else $error("integral outside bounds");
    quiet_between_a: assert property ( // RQ20
        tick_reg |=> !tick_reg ##1 !tick_reg ##1 !tick_reg)
        else $error("sample ticks too close");
    bounds_range_a: assert property ( // RQ15
        cfg_reg.upper_output_bound >= 16'sh0 && cfg_reg.lower_output_bound <= 16'sh0)
        else $error("bound outside its range");
    apb_ready_a: assert property (
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("apb answer not in one cycle");
endmodule : pidc_top

// file: sim/pidc_source_model.sv
// setpoint, feedback and profiled gain sources feeding the loop controller
`timescale 1ns/100ps
module pidc_source_model (
    input  wire logic               i_mclk,
    input  wire logic               i_reset_n,
    input  wire logic               i_load,
    input  wire logic [15:0]        i_sp,
    input  wire logic [15:0]        i_fb,
    input  wire logic [15:0]        i_pg,
    output logic signed [15:0]      o_setpoint,
    output logic signed [15:0]      o_feedback,
    output logic [15:0]             o_profiled_gain
);
    // sources are upstream blocks: they hold a level until told to move
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_setpoint      <= 16'h0000;
            o_feedback      <= 16'h0000;
            o_profiled_gain <= 16'h0000;
        end else if (i_load) begin
            o_setpoint      <= i_sp;
            o_feedback      <= i_fb;
            o_profiled_gain <= i_pg;
        end
    end
endmodule : pidc_source_model

// file: sim/pidc_top_test.sv
// self-checking bench for the loop controller
`timescale 1ns/100ps
module pidc_top_test;
    localparam int SMP = 16;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [7:0]         paddr = 8'h00;
    logic [31:0]        pwdata = 32'h00000000;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               load = 1'b0;
    logic [15:0]        sp_v = 16'h0000;
    logic [15:0]        fb_v = 16'h0000;
    logic [15:0]        pg_v = 16'h0000;
    logic signed [15:0] sp;
    logic signed [15:0] fb;
    logic [15:0]        pg;
    logic signed [15:0] res;
    logic signed [15:0] errv;
    logic               flag;
    logic [31:0]        rd;
    logic               rd_err;
    logic signed [15:0] r0;
    logic signed [15:0] r1;
    logic signed [15:0] mx;
    int                 failures = 0;
    int                 check_count = 0;
    logic [7:0]         ra [8] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
    logic [31:0]        rv [8] = '{32'h20, 32'h100, 32'h0, 32'h10cc, 32'hffffef34, 32'h10001000, 32'h0, 32'h0};

    always #12.5 clk = ~clk;

    pidc_top #(.SAMPLE_CYCLES(SMP)) pidc_top_inst (.i_mclk(clk), .i_reset_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_setpoint(sp), .i_feedback(fb), .i_profiled_gain(pg),
        .o_loop_result(res), .o_loop_error_value(errv), .o_limit_hit_flag(flag));
    pidc_source_model pidc_source_model_inst (.i_mclk(clk), .i_reset_n(rst_n), .i_load(load), .i_sp(sp_v),
        .i_fb(fb_v), .i_pg(pg_v), .o_setpoint(sp), .o_feedback(fb), .o_profiled_gain(pg));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // right after the edge pready still shows what that edge sampled
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check(32'h1, 32'h0);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check({31'h0, rd_err}, {31'h0, ee});
    endtask : rdchk

    task automatic drive(input logic [15:0] s, input logic [15:0] f, input logic [15:0] g, input int t);
        @(posedge clk);
        load <= 1'b1;
        sp_v <= s;
        fb_v <= f;
        pg_v <= g;
        @(posedge clk);
        load <= 1'b0;
        repeat (t * SMP) @(posedge clk);
    endtask : drive

    task automatic outchk(input logic [15:0] er, input logic [15:0] ee);
        @(negedge clk);
        check({16'h0, res}, {16'h0, er});
        check({16'h0, errv}, {16'h0, ee});
    endtask : outchk

    // growth of the result over exactly one sample period
    task automatic slope(input logic [15:0] e);
        repeat (2 * SMP) @(posedge clk);
        @(negedge clk);
        r0 = res;
        repeat (SMP) @(posedge clk);
        @(negedge clk);
        r1 = res;
        check({16'h0, r1 - r0}, {16'h0, e});
    endtask : slope

    task automatic final_report;
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge clk);
        check(32'h1, 32'h0);
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rdchk(ra[i], rv[i], 1'b0);
        rdchk(8'h3c, 32'h0, 1'b1);
        apb(1'b1, pidc_pkg::RES_OFS, 32'h123);
        rdchk(pidc_pkg::RES_OFS, 32'h0, 1'b0);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h2000);
        rdchk(pidc_pkg::UPPER_OFS, 32'h10cc, 1'b0);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'hf000);
        rdchk(pidc_pkg::UPPER_OFS, 32'h0, 1'b0);
        apb(1'b1, pidc_pkg::LOWER_OFS, 32'h0100);
        rdchk(pidc_pkg::LOWER_OFS, 32'h0, 1'b0);
        apb(1'b1, pidc_pkg::LOWER_OFS, 32'he000);
        rdchk(pidc_pkg::LOWER_OFS, 32'hffffef34, 1'b0);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h10cc);
        $display("test registers done");
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h01);
        drive(16'h0800, 16'h0400, 16'h0, 3);
        outchk(16'h0400, 16'h0400);
        rdchk(pidc_pkg::SP_OFS, 32'h800, 1'b0);
        rdchk(pidc_pkg::FB_OFS, 32'h400, 1'b0);
        drive(16'h0400, 16'h0c00, 16'h0, 3);
        outchk(16'hf800, 16'hf800);
        rdchk(pidc_pkg::ERR_OFS, 32'hfffff800, 1'b0);
        rdchk(pidc_pkg::RES_OFS, 32'hfffff800, 1'b0);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h00);
        drive(16'h0400, 16'h0, 16'h0, 3);
        outchk(16'h0000, 16'h0400);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h01);
        drive(16'h2000, 16'h0, 16'h0, 3);
        outchk(16'h10cc, 16'h10cc);
        drive(16'he000, 16'h0, 16'h0, 3);
        outchk(16'hef34, 16'hef34);
        $display("test proportional done");
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h0800);
        drive(16'h0c00, 16'h0, 16'h0, 3);
        outchk(16'h0800, 16'h0c00);
        check({31'h0, flag}, 32'h1);
        rdchk(pidc_pkg::STAT_OFS, 32'h1, 1'b0);
        drive(16'h0400, 16'h0, 16'h0, 3);
        check({31'h0, flag}, 32'h0);
        apb(1'b1, pidc_pkg::LOWER_OFS, 32'hfe00);
        drive(16'hfc00, 16'h0, 16'h0, 3);
        outchk(16'hfe00, 16'hfc00);
        check({31'h0, flag}, 32'h1);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h10cc);
        apb(1'b1, pidc_pkg::LOWER_OFS, 32'hef34);
        $display("test limits done");
        apb(1'b1, pidc_pkg::FINE_OFS, 32'h0100);
        drive(16'h0200, 16'h0, 16'h0300, 3);
        outchk(16'h0400, 16'h0200);
        apb(1'b1, pidc_pkg::FINE_OFS, 32'h0);
        apb(1'b1, pidc_pkg::PROF_OFS, 32'h01);
        drive(16'h0200, 16'h0, 16'h0300, 3);
        outchk(16'h0600, 16'h0200);
        apb(1'b1, pidc_pkg::PROF_OFS, 32'h00);
        drive(16'h0200, 16'h0, 16'h0300, 3);
        outchk(16'h0200, 16'h0200);
        apb(1'b1, pidc_pkg::RATIO_OFS, 32'h10002000);
        drive(16'h0200, 16'h0100, 16'h0, 3);
        outchk(16'h0300, 16'h0300);
        apb(1'b1, pidc_pkg::RATIO_OFS, 32'h20001000);
        drive(16'h0200, 16'h0100, 16'h0, 3);
        outchk(16'h0000, 16'h0000);
        apb(1'b1, pidc_pkg::RATIO_OFS, 32'h10001000);
        $display("test gain and ratio done");
        apb(1'b1, pidc_pkg::ITIME_OFS, 32'h4000);
        drive(16'h0400, 16'h0, 16'h0, 0);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, pidc_pkg::CTRL_OFS, {26'h0, t[1:0], 4'h1});
            slope(t[1] ? 16'h0100 : 16'h0000);
        end
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h25);
        slope(16'h0040);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h23);
        slope(16'h0000);
        outchk(16'h0400, 16'h0400);
        apb(1'b1, pidc_pkg::GAIN_OFS, 32'h0);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h0580);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h21);
        drive(16'h0400, 16'h0, 16'h0, 12);
        outchk(16'h0580, 16'h0400);
        drive(16'h0, 16'h0400, 16'h0, 0);
        slope(16'hff00);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h23);
        apb(1'b1, pidc_pkg::GAIN_OFS, 32'h0100);
        drive(16'h0400, 16'h0, 16'h0, 2);
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h21);
        drive(16'h0400, 16'h0, 16'h0, 8);
        check({31'h0, flag}, 32'h1);
        apb(1'b1, pidc_pkg::ITIME_OFS, 32'h0);
        apb(1'b1, pidc_pkg::UPPER_OFS, 32'h10cc);
        drive(16'h0400, 16'h0, 16'h0, 3);
        // integral held at 'h300 shows once the bound is lifted
        outchk(16'h0700, 16'h0400);
        $display("test integral done");
        apb(1'b1, pidc_pkg::CTRL_OFS, 32'h11);
        apb(1'b1, pidc_pkg::RTIME_OFS, 32'h0100);
        apb(1'b1, pidc_pkg::FTIME_OFS, 32'h8000);
        drive(16'h0, 16'h0, 16'h0, 3);
        drive(16'h0400, 16'h0, 16'h0, 0);
        mx = 16'sh0000;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            if (res > mx) mx = res;
            repeat (SMP) @(posedge clk);
        end
        check({31'h0, mx > 16'sh0400}, 32'h1);
        repeat (30 * SMP) @(posedge clk);
        outchk(16'h0400, 16'h0400);
        // rate term off again, as a configuring host normally keeps it
        apb(1'b1, pidc_pkg::RTIME_OFS, 32'h0);
        $display("test derivative done");
        final_report();
    end
endmodule : pidc_top_test
